// File: hw/arr_pkg.sv
package arr_pkg;

  // Agent identifiers and message fields
  localparam int unsigned ID_W   = 6;
  localparam int unsigned N_IDS  = 64;
  localparam int unsigned TAG_W  = 8;
  localparam int unsigned RESP_W = 2;
  localparam int unsigned NPORT  = 4;
  localparam int unsigned NDST   = 5;   // Four egress ports plus the local copy
  localparam int unsigned DST_LOC = 4;  // Index of the local copy in a forward mask
  localparam int unsigned MRG_N  = 8;   // Merge tracker entries
  localparam int unsigned MRG_W  = 3;
  localparam int unsigned CNT_W  = 3;

  // Register port: address is a word index
  localparam int unsigned ADDR_W = 8;
  localparam logic [1:0] RGN_RMAP = 2'h0;  // 0x00..0x3F agent route map
  localparam logic [1:0] RGN_SMAP = 2'h1;  // 0x40..0x7F snoop response route map
  localparam logic [1:0] RGN_BFV  = 2'h2;  // 0x80..0xBF broadcast forward vector
  localparam logic [7:0] A_CTRL   = 8'hc0;
  localparam logic [7:0] A_STAT   = 8'hc1;

  // Control and status fields
  localparam int unsigned CTRL_ICPT  = 0;  // Intercept incoming completion acknowledges
  localparam int unsigned STAT_ERR   = 0;  // Sticky routing error, write one to clear
  localparam int unsigned STAT_ID_LO = 8;  // Identifier that missed
  localparam int unsigned STAT_BUSY  = 16; // Split in progress
  localparam int unsigned STAT_TRK_LO = 24; // Merge trackers in use

  typedef enum logic [1:0] {
    ARR_MEM_RSP,
    ARR_SNP_REQ,
    ARR_SNP_RSP,
    ARR_COMP_ACK
  } arr_mtype_t;

  typedef enum logic [1:0] {
    ARR_UNI,
    ARR_BC,
    ARR_BCM1
  } arr_skind_t;

  typedef struct packed {
    arr_mtype_t          mtype;
    arr_skind_t          skind;
    logic [ID_W-1:0]     source_agent_id;
    logic [ID_W-1:0]     target_agent_id;
    logic [TAG_W-1:0]    transaction_tag;
    logic [RESP_W-1:0]   resp;
  } arr_msg_t;

  // Route entry, bits [5:0] of the register word
  typedef struct packed {
    logic [1:0] link;
    logic [1:0] port;
    logic       loc;
    logic       vld;
  } arr_route_t;

  typedef struct packed {
    logic       loc;
    logic [1:0] port;
    logic [1:0] link;
  } arr_dest_t;

  localparam int unsigned RT_W = $bits(arr_route_t);

endpackage : arr_pkg

// File: hw/arr_router.sv
// Overview of operation
// - Route map holds 64 entries, one per agent
// - Route by identifier, type picks agent or snoop response map
// - Entry says local or egress port and link
// - Responses retrace request path via same map
// - Snoop responses use separate snoop response map
// - Snoop requests routed reverse of requester path
// - Broadcast forward vector indexed by home identifier
// - Split copies to other ports are broadcast
// - At most one copy stays broadcast-minus-one
// - Splitting point merges all resulting snoop responses
// - Memory tags unique per source per point
// - Snoop tags unique per target pool
// - Merge point keeps forwarded tags unique
// - Agent identifier fields are six bits
// - Home tracks up to 64 request agents
// - Unicast, broadcast, broadcast-minus-one target sets
// - Memory request source is original requester
// - Memory response keeps home and requester identifiers
// - Snoop request source stays original home
// - Merged snoop response: snooped source, home target
// - Completion acknowledges target home, intercept drops them
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module arr_router (
  input  wire logic                          clk,        // 100 MHz clock
  input  wire logic                          rst_n,      // Asynchronous reset
  input  wire logic [arr_pkg::ADDR_W-1:0]    reg_addr,   // Register word index
  input  wire logic [31:0]                   reg_wdata,  // Register write data
  input  wire logic                          reg_wr,     // Write strobe
  input  wire logic                          reg_rd,     // Read strobe
  output logic      [31:0]                   reg_rdata,  // Read data, cycle after strobe
  input  wire logic                          in_vld,     // Incoming message valid
  input  wire arr_pkg::arr_msg_t             in_msg,     // Incoming message
  output logic                               in_rdy,     // Message taken when high
  output logic                               out_vld,    // Routed message pulse
  output arr_pkg::arr_msg_t                  out_msg,    // Routed message
  output arr_pkg::arr_dest_t                 out_dst,    // Local or port and link
  output logic                               route_err   // Sticky routing error
);

  typedef enum {ST_IDLE, ST_SPLIT} arr_state_t;

  localparam logic [arr_pkg::CNT_W-1:0] CNT_ONE = 3'h1;

  // Route maps and forward vector
  arr_pkg::arr_route_t                rmap_mem [arr_pkg::N_IDS];
  arr_pkg::arr_route_t                smap_mem [arr_pkg::N_IDS];
  logic [arr_pkg::NDST-1:0]           bfv_mem  [arr_pkg::N_IDS];
  logic [arr_pkg::N_IDS-1:0]          rmap_vld_r;
  logic [arr_pkg::N_IDS-1:0]          smap_vld_r;
  logic                               ctrl_icpt_r;
  logic                               err_r;
  logic [arr_pkg::ID_W-1:0]           err_id_r;

  // Split state
  arr_state_t                         state_r;
  logic [arr_pkg::NDST-1:0]           pend_r;
  arr_pkg::arr_msg_t                  spl_msg_r;
  arr_pkg::arr_route_t                spl_rt_r;

  // Merge trackers
  logic [arr_pkg::MRG_N-1:0]          trk_act_r;
  logic [arr_pkg::CNT_W-1:0]          trk_cnt_r  [arr_pkg::MRG_N];
  logic [arr_pkg::RESP_W-1:0]         trk_resp_r [arr_pkg::MRG_N];
  logic [arr_pkg::ID_W-1:0]           trk_home_r [arr_pkg::MRG_N];
  logic [arr_pkg::ID_W-1:0]           trk_tgt_r  [arr_pkg::MRG_N];
  logic [arr_pkg::TAG_W-1:0]          trk_tag_r  [arr_pkg::MRG_N];

  // Decode results
  logic                               take;
  logic [arr_pkg::MRG_W-1:0]          tidx;
  arr_pkg::arr_route_t                rt;
  logic [arr_pkg::NDST-1:0]           fmask;
  logic                               split_go;
  logic                               trk_hit;
  logic                               trk_last;
  logic                               drop_ack;
  logic                               fwd;
  logic [2:0]                         sel;
  logic [arr_pkg::NDST-1:0]           pend_rest;
  logic                               emit;
  arr_pkg::arr_msg_t                  emsg;
  arr_pkg::arr_dest_t                 edst;
  logic                               miss;
  logic [arr_pkg::ID_W-1:0]           miss_id;
  logic [arr_pkg::RESP_W-1:0]         mresp;

  // Home entry of the snoop response map for a merged answer
  arr_pkg::arr_route_t                hrt;

  // Lowest set destination of a forward mask
  // Ports come before the local copy, so copies leave in index order
  function automatic logic [2:0] arr_lowest(input logic [arr_pkg::NDST-1:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = arr_pkg::NDST - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : arr_lowest

  // Number of copies in a forward mask
  function automatic logic [arr_pkg::CNT_W-1:0] arr_count(input logic [arr_pkg::NDST-1:0] m);
    logic [arr_pkg::CNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < arr_pkg::NDST; i++) begin
      c = c + arr_pkg::CNT_W'(m[i]);
    end
    return c;
  endfunction : arr_count

  ////////////////////////////////////////////////////////////////////////////////
  // Message decode and routing

  always_comb begin
    take     = in_vld && in_rdy;
    tidx     = in_msg.transaction_tag[arr_pkg::MRG_W-1:0];
    // Snoop responses take their own map, all else the agent map
    if (in_msg.mtype == arr_pkg::ARR_SNP_RSP) begin
      rt = smap_mem[in_msg.target_agent_id];
      rt.vld = smap_vld_r[in_msg.target_agent_id];
    end else begin
      rt = rmap_mem[in_msg.target_agent_id];
      rt.vld = rmap_vld_r[in_msg.target_agent_id];
    end
    fmask    = bfv_mem[in_msg.source_agent_id];
    split_go = take && in_msg.mtype == arr_pkg::ARR_SNP_REQ && in_msg.skind != arr_pkg::ARR_UNI;
    trk_hit  = take && in_msg.mtype == arr_pkg::ARR_SNP_RSP && trk_act_r[tidx]
               && trk_tag_r[tidx] == in_msg.transaction_tag;
    trk_last = trk_hit && trk_cnt_r[tidx] == CNT_ONE;
    drop_ack = take && in_msg.mtype == arr_pkg::ARR_COMP_ACK && ctrl_icpt_r;
    fwd      = take && !split_go && !trk_hit && !drop_ack;
    sel      = arr_lowest(pend_r);
    pend_rest = pend_r & ~(arr_pkg::NDST'(1) << sel);
    // Merged response is the OR of all partial answers
    mresp    = trk_resp_r[tidx] | in_msg.resp;
    hrt      = smap_mem[trk_home_r[tidx]];
    emit     = 1'b0;
    emsg     = in_msg;
    edst     = '0;
    miss     = 1'b0;
    miss_id  = in_msg.target_agent_id;
    // Split copies go first; nothing is taken meanwhile
    if (state_r == ST_SPLIT) begin
      // One copy per cycle; home source and tag kept
      emit = 1'b1;
      emsg = spl_msg_r;
      emsg.skind = arr_pkg::ARR_BC;
      if (sel == 3'(arr_pkg::DST_LOC)) begin
        edst.loc = 1'b1;
        if (spl_rt_r.loc) begin
          emsg.skind = spl_msg_r.skind;
        end
      end else begin
        edst.port = sel[1:0];
        if (!spl_rt_r.loc && spl_rt_r.port == sel[1:0]) begin
          edst.link = spl_rt_r.link;
          emsg.skind = spl_msg_r.skind;
        end
      end
    end else if (split_go && fmask == '0) begin
      // Empty forward vector: the snoop has nowhere to go
      miss = 1'b1;
      miss_id = in_msg.source_agent_id;
    end else if (fwd) begin
      // Same lookup both ways keeps the reverse path
      if (rt.vld) begin
        emit = 1'b1;
        edst.loc = rt.loc;
        edst.port = rt.loc ? 2'h0 : rt.port;
        edst.link = rt.loc ? 2'h0 : rt.link;
      end else begin
        miss = 1'b1;
      end
    end else if (trk_last) begin
      // Merged answer: snooped agent as source, home as target
      emsg.source_agent_id = trk_tgt_r[tidx];
      emsg.target_agent_id = trk_home_r[tidx];
      emsg.resp = mresp;
      miss_id = trk_home_r[tidx];
      if (smap_vld_r[trk_home_r[tidx]]) begin
        emit = 1'b1;
        // Local answers carry no port or link
        edst.loc = hrt.loc;
        edst.port = hrt.loc ? 2'h0 : hrt.port;
        edst.link = hrt.loc ? 2'h0 : hrt.link;
      end else begin
        miss = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Split sequencer
  // Ready stays low while the copies leave, one per cycle, so no new
  // message can overtake a split or overwrite the held snoop

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      pend_r  <= '0;
      in_rdy  <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (split_go && fmask != '0) begin
            state_r <= ST_SPLIT;
            pend_r  <= fmask;
            in_rdy  <= 1'b0;
          end else begin
            in_rdy  <= 1'b1;
          end
        end
        ST_SPLIT: begin
          pend_r <= pend_rest;
          if (pend_rest == '0) begin
            // Last copy leaves now, ready again next cycle
            state_r <= ST_IDLE;
            in_rdy  <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Snoop held for splitting, with its target's route
  always_ff @(posedge clk) begin
    if (split_go) begin
      spl_msg_r <= in_msg;
      spl_rt_r  <= rmap_mem[in_msg.target_agent_id];
      spl_rt_r.vld <= rmap_vld_r[in_msg.target_agent_id];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Merge trackers, indexed by low tag bits
  // Unique snoop tags per target pool keep two live splits apart;
  // a tracker frees itself on the last partial answer

  generate
    for (genvar g = 0; g < arr_pkg::MRG_N; g++) begin : g_trk
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          trk_act_r[g]  <= 1'b0;
          trk_cnt_r[g]  <= '0;
          trk_resp_r[g] <= '0;
          trk_home_r[g] <= '0;
          trk_tgt_r[g]  <= '0;
          trk_tag_r[g]  <= '0;
        end else if (split_go && fmask != '0 && tidx == arr_pkg::MRG_W'(g)) begin
          trk_act_r[g]  <= 1'b1;
          trk_cnt_r[g]  <= arr_count(fmask);
          trk_resp_r[g] <= '0;
          trk_home_r[g] <= in_msg.source_agent_id;
          trk_tgt_r[g]  <= in_msg.target_agent_id;
          trk_tag_r[g]  <= in_msg.transaction_tag;
        end else if (trk_hit && tidx == arr_pkg::MRG_W'(g)) begin
          trk_cnt_r[g]  <= trk_cnt_r[g] - CNT_ONE;
          trk_resp_r[g] <= mresp;
          if (trk_last) begin
            trk_act_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage; tags pass unchanged so source uniqueness holds
  // Message and destination hold between pulses

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_vld <= 1'b0;
      out_msg <= '0;
      out_dst <= '0;
    end else begin
      out_vld <= emit;
      if (emit) begin
        out_msg <= emsg;
        out_dst <= edst;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Map contents; valid bits kept apart so they reset
  // Only the low bits of each entry are kept; the rest is ignored
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr[7:6] == arr_pkg::RGN_RMAP) begin
      rmap_mem[reg_addr[5:0]] <= arr_pkg::arr_route_t'(reg_wdata[arr_pkg::RT_W-1:0]);
    end
    if (reg_wr && reg_addr[7:6] == arr_pkg::RGN_SMAP) begin
      smap_mem[reg_addr[5:0]] <= arr_pkg::arr_route_t'(reg_wdata[arr_pkg::RT_W-1:0]);
    end
    if (reg_wr && reg_addr[7:6] == arr_pkg::RGN_BFV) begin
      bfv_mem[reg_addr[5:0]] <= reg_wdata[arr_pkg::NDST-1:0];
    end
  end

  // Valid bits and control, cleared by reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rmap_vld_r  <= '0;
      smap_vld_r  <= '0;
      ctrl_icpt_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr[7:6] == arr_pkg::RGN_RMAP) begin
        rmap_vld_r[reg_addr[5:0]] <= reg_wdata[0];
      end else if (reg_addr[7:6] == arr_pkg::RGN_SMAP) begin
        smap_vld_r[reg_addr[5:0]] <= reg_wdata[0];
      end else if (reg_addr == arr_pkg::A_CTRL) begin
        ctrl_icpt_r <= reg_wdata[arr_pkg::CTRL_ICPT];
      end
    end
  end

  // Routing error: set wins over a same-cycle clear
  // The mirror output drops on the edge that takes the clear write, with the status bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_r     <= 1'b0;
      err_id_r  <= '0;
      route_err <= 1'b0;
    end else begin
      if (miss) begin
        err_r    <= 1'b1;
        err_id_r <= miss_id;
      end else if (reg_wr && reg_addr == arr_pkg::A_STAT && reg_wdata[arr_pkg::STAT_ERR]) begin
        err_r <= 1'b0;
      end
      route_err <= miss || (err_r &&
                   !(reg_wr && reg_addr == arr_pkg::A_STAT && reg_wdata[arr_pkg::STAT_ERR]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads, data in the following cycle
  // Unmapped indices read as zero

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr[7:6] == arr_pkg::RGN_RMAP) begin
        reg_rdata[arr_pkg::RT_W-1:0] <= {rmap_mem[reg_addr[5:0]][arr_pkg::RT_W-1:1], rmap_vld_r[reg_addr[5:0]]};
      end else if (reg_addr[7:6] == arr_pkg::RGN_SMAP) begin
        reg_rdata[arr_pkg::RT_W-1:0] <= {smap_mem[reg_addr[5:0]][arr_pkg::RT_W-1:1], smap_vld_r[reg_addr[5:0]]};
      end else if (reg_addr[7:6] == arr_pkg::RGN_BFV) begin
        reg_rdata[arr_pkg::NDST-1:0] <= bfv_mem[reg_addr[5:0]];
      end else if (reg_addr == arr_pkg::A_CTRL) begin
        reg_rdata[arr_pkg::CTRL_ICPT] <= ctrl_icpt_r;
      end else if (reg_addr == arr_pkg::A_STAT) begin
        reg_rdata[arr_pkg::STAT_ERR] <= err_r;
        reg_rdata[arr_pkg::STAT_ID_LO +: arr_pkg::ID_W] <= err_id_r;
        reg_rdata[arr_pkg::STAT_BUSY] <= state_r == ST_SPLIT;
        reg_rdata[arr_pkg::STAT_TRK_LO +: arr_pkg::MRG_N] <= trk_act_r;
      end
    end
  end

endmodule : arr_router

// File: tb/arr_peer_model.sv
`timescale 1ns/1ns
module arr_peer_model (
  input wire logic              clk,     // Clock
  input wire logic              rst_n,   // Reset, active low
  input wire logic              out_vld, // Router output valid
  input wire arr_pkg::arr_msg_t out_msg  // Router output message
);
  arr_pkg::arr_msg_t rsp_q[$];
  arr_pkg::arr_msg_t r;

  // Each snooped agent answers its home, keeping the snoop tag
  always @(negedge clk) begin
    if (rst_n && out_vld === 1'b1 && out_msg.mtype == arr_pkg::ARR_SNP_REQ) begin
      r = out_msg;
      r.mtype = arr_pkg::ARR_SNP_RSP;
      r.source_agent_id = out_msg.target_agent_id;
      r.target_agent_id = out_msg.source_agent_id;
      r.resp = 2'($urandom);
      rsp_q.push_back(r);
    end
  end
endmodule : arr_peer_model

// File: tb/arr_router_props.sv
`timescale 1ns/1ns
module arr_router_props (
  input wire logic                       clk,       // Clock
  input wire logic                       rst_n,     // Reset, active low
  input wire logic [arr_pkg::ADDR_W-1:0] reg_addr,  // Register index
  input wire logic [31:0]                reg_wdata, // Write data
  input wire logic                       reg_wr,    // Write strobe
  input wire logic                       reg_rd,    // Read strobe
  input wire logic [31:0]                reg_rdata, // Read data
  input wire logic                       in_vld,    // Message valid
  input wire arr_pkg::arr_msg_t          in_msg,    // Incoming message
  input wire logic                       in_rdy,    // Message taken
  input wire logic                       out_vld,   // Routed pulse
  input wire arr_pkg::arr_msg_t          out_msg,   // Routed message
  input wire arr_pkg::arr_dest_t         out_dst,   // Destination
  input wire logic                       route_err  // Error flag
);
  logic              tk_r;
  logic              clr_r;
  arr_pkg::arr_msg_t m_r;
  arr_pkg::arr_msg_t sp_r;

  // Remember the message taken, the snoop being split and any error clear write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tk_r   <= 1'b0;
      clr_r  <= 1'b0;
      m_r    <= '0;
      sp_r   <= '0;
    end else begin
      tk_r   <= in_vld && in_rdy;
      clr_r  <= reg_wr && reg_addr == arr_pkg::A_STAT && reg_wdata[arr_pkg::STAT_ERR];
      m_r    <= in_msg;
      if (in_vld && in_rdy && in_msg.mtype == arr_pkg::ARR_SNP_REQ && in_msg.skind != arr_pkg::ARR_UNI) begin
        sp_r <= in_msg;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  out_cause_a: assert property (out_vld |-> tk_r || !in_rdy || !$past(in_rdy))
    else $error("output without a taken message");
  tag_keep_a: assert property (out_vld && tk_r |-> out_msg.transaction_tag == m_r.transaction_tag)
    else $error("tag changed on forwarding");
  mem_rsp_a: assert property (out_vld && tk_r && m_r.mtype == arr_pkg::ARR_MEM_RSP |-> out_msg == m_r)
    else $error("memory response fields altered");
  ack_tgt_a: assert property (out_vld && tk_r && m_r.mtype == arr_pkg::ARR_COMP_ACK
    |-> out_msg.target_agent_id == m_r.target_agent_id)
    else $error("acknowledge target altered");
  bc_copy_a: assert property (out_vld && !tk_r && out_msg.mtype == arr_pkg::ARR_SNP_REQ
    |-> out_msg.skind == arr_pkg::ARR_BC || out_msg.skind == sp_r.skind)
    else $error("split copy of wrong kind");
  split_src_a: assert property (out_vld && !tk_r && out_msg.mtype == arr_pkg::ARR_SNP_REQ
    |-> out_msg.source_agent_id == sp_r.source_agent_id && out_msg.target_agent_id == sp_r.target_agent_id
    && out_msg.transaction_tag == sp_r.transaction_tag)
    else $error("split copy lost home, target or tag");
  loc_zero_a: assert property (out_vld && out_dst.loc |-> out_dst.port == 2'h0 && out_dst.link == 2'h0)
    else $error("local destination with port or link");
  err_clr_a: assert property ($fell(route_err) |-> clr_r)
    else $error("error flag fell without clear");
  rdy_drop_a: assert property ($fell(in_rdy) |-> tk_r && m_r.mtype == arr_pkg::ARR_SNP_REQ
    && m_r.skind != arr_pkg::ARR_UNI)
    else $error("ready dropped without split");

  split_c: cover property ($fell(in_rdy));
  merge_c: cover property (out_vld && out_msg.mtype == arr_pkg::ARR_SNP_RSP);
  err_c: cover property ($rose(route_err));
  read_c: cover property (reg_rd);
endmodule : arr_router_props

// File: tb/tb_arr_router.sv
`timescale 1ns/1ns
module tb_arr_router;
  logic                       clk, rst_n, reg_wr, reg_rd, in_vld, in_rdy, out_vld, route_err;
  logic [arr_pkg::ADDR_W-1:0] reg_addr;
  logic [31:0]                reg_wdata, reg_rdata;
  arr_pkg::arr_msg_t          in_msg, out_msg, m, em_q[$];
  arr_pkg::arr_dest_t         out_dst, ed_q[$];
  int                         failures, checks;

  arr_router i_arr_router (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_vld(in_vld), .in_msg(in_msg),
    .in_rdy(in_rdy), .out_vld(out_vld), .out_msg(out_msg), .out_dst(out_dst), .route_err(route_err));
  arr_peer_model i_arr_peer_model (.clk(clk), .rst_n(rst_n), .out_vld(out_vld), .out_msg(out_msg));

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(nm, reg_rdata, e);
  endtask : rd

  task automatic send(arr_pkg::arr_msg_t mm);
    int n;
    n = 0;
    @(posedge clk);
    in_msg <= mm;
    in_vld <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (in_rdy !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      give_verdict();
    end else begin
      @(posedge clk);
      in_vld <= 1'b0;
    end
  endtask : send

  task automatic ex(arr_pkg::arr_msg_t mm, arr_pkg::arr_dest_t d);
    em_q.push_back(mm);
    ed_q.push_back(d);
  endtask : ex

  function automatic arr_pkg::arr_msg_t mk(arr_pkg::arr_mtype_t t, arr_pkg::arr_skind_t k, logic [5:0] s, g);
    mk = '{t, k, s, g, 8'($urandom), 2'($urandom)};
  endfunction : mk

  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare each routed message with the oldest expectation
  always @(negedge clk) begin
    if (out_vld === 1'b1) begin
      if (em_q.size() == 0) chk("unexpected out", 32'h1, 32'h0);
      else begin
        m = out_msg;
        if (m.mtype == arr_pkg::ARR_SNP_RSP) m.skind = em_q[0].skind;
        chk("out_msg", 32'(m), 32'(em_q.pop_front()));
        chk("out_dst", 32'(out_dst), 32'(ed_q.pop_front()));
      end
    end
  end

  // Cut a hung run short
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // Main sequence
  initial begin
    arr_pkg::arr_msg_t s, r0, r1, e;
    {reg_wr, reg_rd, in_vld, reg_addr, reg_wdata} = '0;
    in_msg = '0;
    rst_n = 1'b0;
    void'($urandom(32'h7782_2a69));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(8'h01, 32'h0000_0003);
    wr(8'h02, 32'h0000_0019);
    wr(8'h3f, 32'h0000_0025);
    wr(8'h45, 32'h0000_0005);
    wr(8'h85, 32'h0000_0011);
    rd(8'h3f, 32'h0000_0025, "map top");
    rd(8'hd0, 32'h0000_0000, "unmapped");
    $display("test registers done");
    // Forwarding by route map and acknowledge interception
    s = mk(arr_pkg::ARR_MEM_RSP, arr_pkg::ARR_UNI, 6'h05, 6'h02);
    ex(s, '{1'b0, 2'h2, 2'h1});
    send(s);
    s = mk(arr_pkg::ARR_MEM_RSP, arr_pkg::ARR_UNI, 6'h05, 6'h01);
    ex(s, '{1'b1, 2'h0, 2'h0});
    send(s);
    s = mk(arr_pkg::ARR_COMP_ACK, arr_pkg::ARR_UNI, 6'h01, 6'h02);
    ex(s, '{1'b0, 2'h2, 2'h1});
    send(s);
    wr(arr_pkg::A_CTRL, 32'h0000_0001);
    send(mk(arr_pkg::ARR_COMP_ACK, arr_pkg::ARR_UNI, 6'h01, 6'h02));
    repeat (3) @(posedge clk);
    chk("pending", em_q.size(), 32'h0000_0000);
    $display("test forward done");
    // Miss on an invalid entry and on an empty forward vector
    send(mk(arr_pkg::ARR_MEM_RSP, arr_pkg::ARR_UNI, 6'h05, 6'h03));
    repeat (3) @(posedge clk);
    chk("route_err set", route_err, 32'h0000_0001);
    rd(arr_pkg::A_STAT, 32'h0000_0301, "status");
    wr(arr_pkg::A_STAT, 32'h0000_0001);
    wr(8'h86, 32'h0000_0000);
    send(mk(arr_pkg::ARR_SNP_REQ, arr_pkg::ARR_BC, 6'h06, 6'h02));
    repeat (3) @(posedge clk);
    rd(arr_pkg::A_STAT, 32'h0000_0601, "empty vector");
    wr(arr_pkg::A_STAT, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("route_err clear", route_err, 32'h0000_0000);
    $display("test miss done");
    // Every snoop kind; broadcast kinds split, then merge of the answers
    for (int k = 0; k < 3; k++) begin
      s = mk(arr_pkg::ARR_SNP_REQ, arr_pkg::arr_skind_t'(k), 6'h05, (k == 2) ? 6'h01 : 6'h02);
      if (k == 0) ex(s, '{1'b0, 2'h2, 2'h1});
      else begin
        r0 = s;
        r0.skind = arr_pkg::ARR_BC;
        ex(r0, '{1'b0, 2'h0, 2'h0});
        r1 = s;
        r1.skind = (k == 2) ? arr_pkg::ARR_BCM1 : arr_pkg::ARR_BC;
        ex(r1, '{1'b1, 2'h0, 2'h0});
      end
      send(s);
      repeat (4) @(posedge clk);
      r0 = i_arr_peer_model.rsp_q.pop_front();
      r1 = (k > 0) ? i_arr_peer_model.rsp_q.pop_front() : r0;
      e = r0;
      e.source_agent_id = s.target_agent_id;
      e.resp = r0.resp | r1.resp;
      ex(e, '{1'b0, 2'h1, 2'h0});
      send(r0);
      if (k > 0) send(r1);
      repeat (3) @(posedge clk);
      chk("merge pending", em_q.size(), 32'h0000_0000);
    end
    $display("test snoop done");
    give_verdict();
  end
endmodule : tb_arr_router

bind arr_router arr_router_props i_arr_router_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_vld(in_vld),
  .in_msg(in_msg), .in_rdy(in_rdy), .out_vld(out_vld), .out_msg(out_msg), .out_dst(out_dst),
  .route_err(route_err));
